// ### src/spc_regs.svh
// Register offsets, field positions, reset values and timing counts for suspend power control
`ifndef SPC_REGS_SVH
`define SPC_REGS_SVH

// Register byte addresses
`define SPC_ADDR_IRQ        16'h0310
`define SPC_ADDR_PDC        16'h0354
`define SPC_ADDR_P1         16'h0374

// Suspend power-down control fields
`define SPC_PDC_KEEP_ON     0
`define SPC_PDC_OC1         1
`define SPC_PDC_OC2         2
`define SPC_PDC_OC3         3
`define SPC_PDC_LOW_RST     4'h0
`define SPC_WAKE_RST32      16'h03e8
`define SPC_WAKE_RST16      16'h1400

// Port one control fields
`define SPC_P1_INIT_FLAG    7
`define SPC_P1_INIT_CLEAR   23
`define SPC_P1_PWR_LSB      3
`define SPC_P1_LOW_RST      7'h16
`define SPC_P1_FLAG_RST     1'b1

// Interrupt status fields
`define SPC_IRQ_CLK_READY   6

// Timing
`define SPC_CLK_PERIOD_NS   4
`define SPC_SLOW_PERIOD_NS  10000
`define SPC_SLOW_DIV        (`SPC_SLOW_PERIOD_NS / `SPC_CLK_PERIOD_NS)
`define SPC_SETTLE_NS       2000
`define SPC_SETTLE_CYC      ((`SPC_SETTLE_NS + `SPC_CLK_PERIOD_NS - 1) / `SPC_CLK_PERIOD_NS)

`endif

// ### src/spc_pkg.sv
// Types shared by the suspend power control block
package spc_pkg;

   // Clock sequencer states
   typedef enum logic [1:0] {
      SPC_RUN    = 2'b00,
      SPC_STOP   = 2'b01,
      SPC_SETTLE = 2'b10
   } spc_clk_state_t;

endpackage

// ### src/spc_clk_ctrl.sv
// Slow suspend clock divider and internal clock stop and restart sequencer
`timescale 1ns/100ps
`default_nettype none
`include "spc_regs.svh"

module spc_clk_ctrl (
   input  wire logic clk_i,
   input  wire logic rst_i,
   input  wire logic suspend_i,
   input  wire logic keep_on_i,
   output logic      clk_run_o,
   output logic      slow_tick_o,
   output logic      ready_evt_o
);

   localparam int SETTLE_CYC = `SPC_SETTLE_CYC;

   logic [11:0]             div_r;
   logic [9:0]              settle_r;
   spc_pkg::spc_clk_state_t state_r;

   ////////////////////////////////////////////////////////////////////////////////
   // Slow clock, free running in every state
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         div_r       <= 12'h000;
         slow_tick_o <= 1'b0;
      end else if (div_r == 12'(`SPC_SLOW_DIV - 1)) begin
         div_r       <= 12'h000;
         slow_tick_o <= 1'b1;
      end else begin
         div_r       <= div_r + 12'h001;
         slow_tick_o <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Stop on suspend unless kept on, settle after resume
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         state_r     <= spc_pkg::SPC_RUN;
         settle_r    <= 10'h000;
         clk_run_o   <= 1'b1;
         ready_evt_o <= 1'b0;
      end else begin
         ready_evt_o <= 1'b0;
         case (state_r)
            spc_pkg::SPC_RUN: begin
               if (suspend_i && !keep_on_i) begin
                  state_r   <= spc_pkg::SPC_STOP;
                  clk_run_o <= 1'b0;
               end
            end
            spc_pkg::SPC_STOP: begin
               if (!suspend_i) begin
                  state_r   <= spc_pkg::SPC_SETTLE;
                  settle_r  <= 10'h000;
                  clk_run_o <= 1'b1;
               end
            end
            spc_pkg::SPC_SETTLE: begin
               if (settle_r == 10'(SETTLE_CYC - 1)) begin
                  state_r     <= spc_pkg::SPC_RUN;
                  ready_evt_o <= 1'b1;
               end else begin
                  settle_r <= settle_r + 10'h001;
               end
            end
            default: begin
               state_r   <= spc_pkg::SPC_RUN;
               clk_run_o <= 1'b1;
            end
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   property p_stop_clocks;
      (state_r == spc_pkg::SPC_RUN && suspend_i && !keep_on_i) |=> !clk_run_o;
   endproperty
   a_stop_clocks: assert property (p_stop_clocks) else $error("clocks not stopped");

   property p_keep_clocks;
      (state_r == spc_pkg::SPC_RUN && keep_on_i) |=> clk_run_o && state_r == spc_pkg::SPC_RUN;
   endproperty
   a_keep_clocks: assert property (p_keep_clocks) else $error("clocks stopped while kept on");

   property p_slow_tick;
      slow_tick_o |=> !slow_tick_o [*8];
   endproperty
   a_slow_tick: assert property (p_slow_tick) else $error("slow tick too frequent");

   sequence s_resume;
      state_r == spc_pkg::SPC_STOP && !suspend_i;
   endsequence
   sequence s_ready;
      ##[1:600] ready_evt_o;
   endsequence
   property p_ready_after_resume;
      s_resume |=> s_ready;
   endproperty
   a_ready_after_resume: assert property (p_ready_after_resume) else $error("no ready event");

   property p_ready_only_settled;
      ready_evt_o |-> $past(state_r) == spc_pkg::SPC_SETTLE && clk_run_o;
   endproperty
   a_ready_only_settled: assert property (p_ready_only_settled) else $error("early ready");

endmodule
`default_nettype wire

// ### src/spc_suspend_port_ctrl.sv
// Suspend power-down control, port one control and clock-ready status registers
`timescale 1ns/100ps
`default_nettype none
`include "spc_regs.svh"

module spc_suspend_port_ctrl (
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        bus16_i,
   input  wire logic        cs_i,
   input  wire logic        rd_i,
   input  wire logic        wr_i,
   input  wire logic [15:0] addr_i,
   input  wire logic [31:0] wdata_i,
   input  wire logic        suspend_i,
   output logic      [31:0] rdata_o,
   output logic      [15:0] wake_count_o,
   output logic             port3_overcurrent_power_o,
   output logic             port2_overcurrent_power_o,
   output logic             port1_overcurrent_power_o,
   output logic             clk_run_o,
   output logic             slow_suspend_clock_o,
   output logic             clock_ready_irq_o,
   output logic             port_one_power_field_en_o,
   output logic             port1_ready_o
);

   logic [3:0]  pdc_r;
   logic [15:0] wake_r;
   logic [6:0]  p1_low_r;
   logic        init_flag_r;
   logic        clk_ready_r;
   logic        ready_evt;
   logic        wr_pdc;
   logic        wr_p1;
   logic        wr_irq;

   ////////////////////////////////////////////////////////////////////////////////
   // Address decode
   function automatic logic hit(input logic [15:0] a, input logic [15:0] base);
      hit = (a == base);
   endfunction

   assign wr_pdc = cs_i && wr_i && hit(addr_i, `SPC_ADDR_PDC);
   assign wr_p1  = cs_i && wr_i && hit(addr_i, `SPC_ADDR_P1);
   assign wr_irq = cs_i && wr_i && hit(addr_i, `SPC_ADDR_IRQ);

   // Port one lower half as read, mirrored into the upper half
   function automatic logic [15:0] p1_half(input logic flag, input logic [6:0] low);
      p1_half = {8'h00, flag, low};
   endfunction

   ////////////////////////////////////////////////////////////////////////////////
   // Suspend power-down control bits
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         pdc_r <= `SPC_PDC_LOW_RST;
      end else if (wr_pdc) begin
         pdc_r <= wdata_i[3:0];
      end
   end

   // Wake-up counter, default and write behaviour set by bus width
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wake_r <= bus16_i ? `SPC_WAKE_RST16 : `SPC_WAKE_RST32;
      end else if (wr_pdc) begin
         wake_r <= bus16_i ? `SPC_WAKE_RST16 : wdata_i[31:16];
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Port one control: init flag, power field, reserved low bits
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         p1_low_r    <= `SPC_P1_LOW_RST;
         init_flag_r <= `SPC_P1_FLAG_RST;
      end else if (wr_p1) begin
         p1_low_r <= wdata_i[6:0];
         if (wdata_i[`SPC_P1_INIT_CLEAR]) begin
            init_flag_r <= 1'b0;
         end else begin
            init_flag_r <= wdata_i[`SPC_P1_INIT_FLAG];
         end
      end
   end

   // Port one status: power enable from the power field only, ready from the power field and the init flag
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         port_one_power_field_en_o <= 1'b0;
         port1_ready_o    <= 1'b0;
      end else begin
         port_one_power_field_en_o <= &p1_low_r[`SPC_P1_PWR_LSB +: 2];
         port1_ready_o    <= &p1_low_r[`SPC_P1_PWR_LSB +: 2] && !init_flag_r;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Overcurrent detection power in suspend
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         port3_overcurrent_power_o <= 1'b1;
         port2_overcurrent_power_o <= 1'b1;
         port1_overcurrent_power_o <= 1'b1;
      end else begin
         port3_overcurrent_power_o <= !(suspend_i && pdc_r[`SPC_PDC_OC3]);
         port2_overcurrent_power_o <= !(suspend_i && pdc_r[`SPC_PDC_OC2]);
         port1_overcurrent_power_o <= !(suspend_i && pdc_r[`SPC_PDC_OC1]);
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Clock sequencer and slow clock
   spc_clk_ctrl u_clk (
      .clk_i       (clk_i),
      .rst_i       (rst_i),
      .suspend_i   (suspend_i),
      .keep_on_i   (pdc_r[`SPC_PDC_KEEP_ON]),
      .clk_run_o   (clk_run_o),
      .slow_tick_o (slow_suspend_clock_o),
      .ready_evt_o (ready_evt)
   );

   // Sticky clock-ready flag, write 1 clears, new event wins
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         clk_ready_r <= 1'b0;
      end else if (ready_evt) begin
         clk_ready_r <= 1'b1;
      end else if (wr_irq && wdata_i[`SPC_IRQ_CLK_READY]) begin
         clk_ready_r <= 1'b0;
      end
   end

   // Interrupt line follows the flag
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         clock_ready_irq_o <= 1'b0;
      end else begin
         clock_ready_irq_o <= clk_ready_r;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Read data, registered, unmapped reads return zero
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         rdata_o <= 32'h0000_0000;
      end else if (cs_i && rd_i) begin
         if (hit(addr_i, `SPC_ADDR_PDC)) begin
            rdata_o <= {wake_r, 12'h000, pdc_r};
         end else if (hit(addr_i, `SPC_ADDR_P1)) begin
            rdata_o <= {p1_half(init_flag_r, p1_low_r), p1_half(init_flag_r, p1_low_r)};
         end else if (hit(addr_i, `SPC_ADDR_IRQ)) begin
            rdata_o <= {25'h0, clk_ready_r, 6'h00};
         end else begin
            rdata_o <= 32'h0000_0000;
         end
      end
   end

   // Wake counter output
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wake_count_o <= 16'h0000;
      end else begin
         wake_count_o <= wake_r;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   property p_oc3_off;
      (suspend_i && pdc_r[`SPC_PDC_OC3]) |=> !port3_overcurrent_power_o;
   endproperty
   a_oc3_off: assert property (p_oc3_off) else $error("port3 detect powered");

   property p_oc2_on;
      (!suspend_i || !pdc_r[`SPC_PDC_OC2]) |=> port2_overcurrent_power_o;
   endproperty
   a_oc2_on: assert property (p_oc2_on) else $error("port2 detect unpowered");

   sequence s_oc1_write_off;
      wr_pdc && wdata_i[`SPC_PDC_OC1] ##1 suspend_i;
   endsequence
   property p_oc1_off;
      s_oc1_write_off |=> !port1_overcurrent_power_o;
   endproperty
   a_oc1_off: assert property (p_oc1_off) else $error("port1 detect powered");

   property p_mirror;
      $past(cs_i && rd_i && hit(addr_i, `SPC_ADDR_P1)) |-> rdata_o[31:16] == rdata_o[15:0];
   endproperty
   a_mirror: assert property (p_mirror) else $error("port1 halves differ");

   sequence s_init_clear;
      wr_p1 && wdata_i[`SPC_P1_INIT_CLEAR];
   endsequence
   property p_init_clear;
      s_init_clear |=> !init_flag_r ##1 (port1_ready_o == port_one_power_field_en_o);
   endproperty
   a_init_clear: assert property (p_init_clear) else $error("init flag not cleared");

   property p_sticky;
      (clk_ready_r && !(wr_irq && wdata_i[`SPC_IRQ_CLK_READY])) |=> clk_ready_r;
   endproperty
   a_sticky: assert property (p_sticky) else $error("ready flag lost");

   property p_irq_follows;
      ready_evt |=> ##1 clock_ready_irq_o;
   endproperty
   a_irq_follows: assert property (p_irq_follows) else $error("irq not raised");

   property p_wake_default;
      $past(rst_i) |-> wake_r == ($past(bus16_i) ? `SPC_WAKE_RST16 : `SPC_WAKE_RST32);
   endproperty
   a_wake_default: assert property (disable iff (1'b0) p_wake_default)
      else $error("wrong wake default");

endmodule
`default_nettype wire

// ### tb/testbench.sv
// Self-checking testbench for the suspend power and port one control registers
`timescale 1ns/100ps
`default_nettype none
`define CHK(g, e) begin num_checks++; if ((g) !== (e)) begin n_errors++; \
   $display("mismatch at %0t got %h expected %h", $time, (g), (e)); end end

module testbench;
   logic        clk, rst, bus16, cs, rd_s, wr_s, susp, probe_req;
   logic        oc3, oc2, oc1, run, slow, irq, pwr_en, p1_rdy;
   logic        rd_pend = 1'b0;
   logic [15:0] addr, wake_count_o;
   logic [31:0] wdata, rdata_o, stat, r, pdc;
   logic [31:0] gap = 32'h0;
   logic [31:0] last_gap = 32'h0;
   logic [33:0] exp_q[$];
   logic [33:0] note;
   integer      n_errors, num_checks, seed;

   ////////////////////////////////////////////////////////////////////////////
   spc_suspend_port_ctrl spc_suspend_port_ctrl_inst (
      .clk_i                     (clk),
      .rst_i                     (rst),
      .bus16_i                   (bus16),
      .cs_i                      (cs),
      .rd_i                      (rd_s),
      .wr_i                      (wr_s),
      .addr_i                    (addr),
      .wdata_i                   (wdata),
      .suspend_i                 (susp),
      .rdata_o                   (rdata_o),
      .wake_count_o              (wake_count_o),
      .port3_overcurrent_power_o (oc3),
      .port2_overcurrent_power_o (oc2),
      .port1_overcurrent_power_o (oc1),
      .clk_run_o                 (run),
      .slow_suspend_clock_o      (slow),
      .clock_ready_irq_o         (irq),
      .port_one_power_field_en_o          (pwr_en),
      .port1_ready_o             (p1_rdy)
   );

   // Level outputs packed for one compare
   assign stat = {wake_count_o, 8'h00, oc3, oc2, oc1, run, irq, pwr_en, p1_rdy, 1'b0};

   // 250 MHz clock
   always #2 clk = ~clk;

   ////////////////////////////////////////////////////////////////////////////
   // Expected status word
   function automatic logic [31:0] st(input logic [15:0] w, input logic [2:0] oc,
                                      input logic rn, input logic iq, input logic en,
                                      input logic rdy);
      return {w, 8'h00, oc, rn, iq, en, rdy, 1'b0};
   endfunction

   // Register write, one strobe cycle
   task automatic wr(input logic [15:0] a, input logic [31:0] d);
      @(posedge clk);
      #1;
      cs = 1'b1; wr_s = 1'b1; addr = a; wdata = d;
      @(posedge clk);
      #1;
      cs = 1'b0; wr_s = 1'b0;
   endtask

   // Register read, expected data noted first
   task automatic rd(input logic [15:0] a, input logic [31:0] e);
      exp_q.push_back({2'd0, e});
      @(posedge clk);
      #1;
      cs = 1'b1; rd_s = 1'b1; addr = a;
      @(posedge clk);
      #1;
      cs = 1'b0; rd_s = 1'b0;
   endtask

   // Output sample request: kind 1 status word, kind 2 slow tick spacing
   task automatic probe(input logic [1:0] k, input logic [31:0] e);
      exp_q.push_back({k, e});
      probe_req = 1'b1;
      @(posedge clk);
      #1;
      probe_req = 1'b0;
   endtask

   // Synchronous reset for 16 cycles
   task automatic do_reset;
      rst = 1'b1;
      repeat (16) @(posedge clk);
      #1;
      rst = 1'b0;
   endtask

   task automatic test_end(input string name);
      $display("test %s done, checks %0d", name, num_checks);
   endtask

   task automatic test_done;
      $display("checks %0d mismatches %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // Monitor: read data one edge after the read, then sampled outputs
   always @(posedge clk) begin
      if (rd_pend) begin
         note = exp_q.pop_front();
         `CHK(rdata_o, note[31:0])
      end
      if (probe_req) begin
         note = exp_q.pop_front();
         if (note[33:32] == 2'd1)
            `CHK(stat, note[31:0])
         else
            `CHK(last_gap, note[31:0])
      end
      rd_pend <= cs & rd_s & ~rst;
      gap <= slow ? 32'h1 : gap + 32'h1;
      if (slow)
         last_gap <= gap;
   end

   // Watchdog against a hung run
   initial begin
      repeat (40000) @(posedge clk);
      n_errors++;
      test_done;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      clk = 1'b0; rst = 1'b1; bus16 = 1'b0; cs = 1'b0; rd_s = 1'b0; wr_s = 1'b0;
      susp = 1'b0; addr = 16'h0000; wdata = 32'h0; probe_req = 1'b0;
      n_errors = 0; num_checks = 0; seed = 55;
      do_reset;
      // Reset state, mirrored halves, unmapped read
      // Wake copy still shows its reset zero, then the counter default one edge later
      probe(2'd1, st(16'h0000, 3'b111, 1'b1, 1'b0, 1'b0, 1'b0));
      probe(2'd1, st(16'h03e8, 3'b111, 1'b1, 1'b0, 1'b0, 1'b0));
      rd(16'h0374, 32'h0096_0096);
      rd(16'h0354, 32'h03e8_0000);
      rd(16'h0300, 32'h0000_0000);
      test_end("reset");
      // Init flag stored raw, then one-shot clear with power field set
      wr(16'h0374, 32'h0000_0098);
      rd(16'h0374, 32'h0098_0098);
      probe(2'd1, st(16'h03e8, 3'b111, 1'b1, 1'b0, 1'b1, 1'b0));
      wr(16'h0374, 32'h0080_0018);
      rd(16'h0374, 32'h0018_0018);
      probe(2'd1, st(16'h03e8, 3'b111, 1'b1, 1'b0, 1'b1, 1'b1));
      test_end("port one");
      // Every overcurrent code, clocks kept on in suspend
      for (int i = 0; i < 16; i++) begin
         r = $random(seed);
         pdc = {16'h03e8, 12'h000, i[2:0], 1'b1};
         wr(16'h0354, pdc);
         susp = (i < 8) | r[0];
         rd(16'h0354, pdc);
         probe(2'd1, st(16'h03e8, ~({3{susp}} & i[2:0]), 1'b1, 1'b0, 1'b1, 1'b1));
      end
      susp = 1'b0;
      test_end("overcurrent");
      // Clock stop, slow tick, restart and sticky ready flag
      wr(16'h0354, 32'h03e8_0000);
      susp = 1'b1;
      repeat (2) @(posedge clk);
      #1;
      probe(2'd1, st(16'h03e8, 3'b111, 1'b0, 1'b0, 1'b1, 1'b1));
      repeat (6000) @(posedge clk);
      #1;
      probe(2'd2, 32'd2500);
      susp = 1'b0;
      repeat (100) @(posedge clk);
      #1;
      probe(2'd1, st(16'h03e8, 3'b111, 1'b1, 1'b0, 1'b1, 1'b1));
      repeat (430) @(posedge clk);
      #1;
      probe(2'd1, st(16'h03e8, 3'b111, 1'b1, 1'b1, 1'b1, 1'b1));
      rd(16'h0310, 32'h0000_0040);
      wr(16'h0310, 32'h0000_0040);
      rd(16'h0310, 32'h0000_0000);
      probe(2'd1, st(16'h03e8, 3'b111, 1'b1, 1'b0, 1'b1, 1'b1));
      test_end("clock ready");
      // 16-bit bus: fixed wake value, read and write back
      bus16 = 1'b1;
      do_reset;
      rd(16'h0354, 32'h1400_0000);
      wr(16'h0354, 32'h1400_0000);
      wr(16'h0354, 32'hffff_0000);
      rd(16'h0354, 32'h1400_0000);
      probe(2'd1, st(16'h1400, 3'b111, 1'b1, 1'b0, 1'b0, 1'b0));
      test_end("bus width");
      test_done;
   end
endmodule
`default_nettype wire
